/* design/sqafs_pkg.sv */
package sqafs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int SQAFS_CHANNELS = 8;
  localparam int SQAFS_ENABLE_INPUTS = 4;
  localparam int SQAFS_PARITY_BIT = 13;

  ////////////////////////////////////////////////////////////////////////////
  // Frame encodings
  localparam logic [1:0] SQAFS_MODE_DEPLOY = 2'h1;
  localparam logic [4:0] SQAFS_ARM_PATTERN = 5'h19;
  localparam logic [4:0] SQAFS_FIRE_PATTERN = 5'h00;
  localparam logic [15:0] SQAFS_RESP_SEQ_ERR = 16'hD005;
  localparam logic [15:0] SQAFS_RESP_BUSY = 16'hD009;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [1:0] SQAFS_LATCH_RESET = 2'h0;
  localparam logic [7:0] SQAFS_MASK_RESET = 8'h00;
  localparam logic [15:0] SQAFS_WORD_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int SQAFS_CLK_KHZ = 200000;
  localparam int SQAFS_STRETCH_UNIT_MS = 128;
  localparam int SQAFS_FIRE_WAIT_MS = 512;
  localparam int SQAFS_STRETCH_UNIT_CYCLES =
    SQAFS_STRETCH_UNIT_MS * SQAFS_CLK_KHZ;
  localparam int SQAFS_FIRE_WAIT_CYCLES = SQAFS_FIRE_WAIT_MS * SQAFS_CLK_KHZ;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [1:0] mode;
    logic parity;
    logic [4:0] pattern;
    logic [7:0] mask;
  } sqafs_frame_t;

  typedef struct packed {
    logic owned;
    logic [15:0] word;
  } sqafs_resp_t;

  typedef enum logic [0:0] {
    SQAFS_SEQ_IDLE = 1'b0,
    SQAFS_SEQ_ARMED = 1'b1
  } sqafs_seq_t;

endpackage

/* design/sqafs_stretch.sv */
module sqafs_stretch #(
  parameter int UNIT_CYCLES = sqafs_pkg::SQAFS_STRETCH_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable_in,
  input wire logic [1:0] latch_sel,
  output logic active
);
  import sqafs_pkg::*;

  logic [31:0] count;
  logic [31:0] reload;

  // 00 none, 01 one unit, 10 two units, 11 four units
  assign reload = (latch_sel == 2'h0) ? 32'h0 :
                  (latch_sel == 2'h1) ? 32'(UNIT_CYCLES) :
                  (latch_sel == 2'h2) ? 32'(2 * UNIT_CYCLES) :
                  32'(4 * UNIT_CYCLES);

  // The stretch holds while the input is high and runs down after it drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h0;
    end else if (enable_in) begin
      count <= reload;
    end else if (count != 32'h0) begin
      count <= count - 32'h1;
    end
  end

  assign active = enable_in | (count != 32'h0);

endmodule

/* design/sqafs_sequencer.sv */
// Summary of operation
// - Frames carry odd parity over all sixteen bits, held in bit 13.
// - Arm frame: top bits 01, bits 12..8 = 11001, low byte arm mask.
// - Fire frame: top bits 01, bits 12..8 = 00000, low byte fire mask.
// - Deployment frames with any other pattern in bits 12..8 are ignored.
// - Only arm directly followed by fire, with fire enable, starts firing.
// - Any interruption voids the sequence; a new arm is needed first.
// - An intervening other command breaks it; later fire answers 0xD005.
// - Fire after fire is out of sequence, ignored, starts nothing.
// - Only channels set in both arm and fire masks are activated.
// - Firing needs fire enable, direct input or its latched stretch.
// - Deploy status goes to one on a valid fire for that channel.
// - Status clears on fire-enable wait timeout or driver switch-off.
// - Fire response low byte gives firing or waiting channels.
// - Each response goes out in the next frame, for the previous command.
// - Commands aimed at deploying channels are ignored, answered 0xD009.
// - After reset no channel is armed.
// - Four stretch timers, shared setting 0/128/256/512 ms, reset 0 ms.
module sqafs_sequencer #(
  parameter int STRETCH_UNIT_CYCLES = sqafs_pkg::SQAFS_STRETCH_UNIT_CYCLES,
  parameter int FIRE_WAIT_CYCLES = sqafs_pkg::SQAFS_FIRE_WAIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic frame_valid,
  input wire logic [15:0] frame_word,
  input wire logic [3:0] fire_enable_channel_input,
  input wire logic [7:0] fire_done,
  input wire logic latch_load,
  input wire logic [1:0] latch_sel,
  output sqafs_pkg::sqafs_resp_t miso_resp,
  output logic [7:0] driver_on,
  output logic [7:0] deploy_status,
  output logic [7:0] armed_mask,
  output logic [1:0] latch_setting,
  output logic seq_armed
);
  import sqafs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Frame decode

  sqafs_frame_t frame;
  logic parity_ok;
  logic is_deploy;
  logic is_arm;
  logic is_fire;
  logic busy_hit;
  logic arm_ok;
  logic fire_ok;
  logic [7:0] fire_set;

  sqafs_seq_t seq;
  sqafs_seq_t next_seq;
  logic [7:0] arm_mask;
  logic [7:0] next_arm_mask;

  assign frame = sqafs_frame_t'(frame_word);
  assign parity_ok = ^frame_word;
  // A corrupted word decodes as no command, yet still voids the sequence and clears the response
  assign is_deploy = parity_ok && (frame.mode == SQAFS_MODE_DEPLOY);
  assign is_arm = is_deploy && (frame.pattern == SQAFS_ARM_PATTERN);
  assign is_fire = is_deploy && (frame.pattern == SQAFS_FIRE_PATTERN);
  assign busy_hit = |(frame.mask & deploy_status);
  assign arm_ok = is_arm && !busy_hit;
  assign fire_ok = is_fire && !busy_hit && (seq == SQAFS_SEQ_ARMED);
  assign fire_set = fire_ok ? (arm_mask & frame.mask) : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Arm-then-fire sequence

  // Every accepted frame leaves the armed state unless it is itself a
  // good arm, so a fire is only honoured right after its arm.
  always_comb begin
    next_seq = seq;
    next_arm_mask = arm_mask;
    if (frame_valid) begin
      if (arm_ok) begin
        next_seq = SQAFS_SEQ_ARMED;
        next_arm_mask = frame.mask;
      end else begin
        next_seq = SQAFS_SEQ_IDLE;
        next_arm_mask = SQAFS_MASK_RESET;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq <= SQAFS_SEQ_IDLE;
      arm_mask <= SQAFS_MASK_RESET;
    end else begin
      seq <= next_seq;
      arm_mask <= next_arm_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fire enable stretch

  logic [3:0] enable_active;
  logic [7:0] enable_channel;
  logic [1:0] latch_cfg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_cfg <= SQAFS_LATCH_RESET;
    end else if (latch_load) begin
      latch_cfg <= latch_sel;
    end
  end

  genvar g;
  generate
    for (g = 0; g < SQAFS_ENABLE_INPUTS; g++) begin : gen_enable
      sqafs_stretch #(
        .UNIT_CYCLES(STRETCH_UNIT_CYCLES)
      ) u_stretch (
        .clk(clk),
        .rst_n(rst_n),
        .enable_in(fire_enable_channel_input[g]),
        .latch_sel(latch_cfg),
        .active(enable_active[g])
      );
    end
    // Each enable input serves a pair of neighbouring channels
    for (g = 0; g < SQAFS_CHANNELS; g++) begin : gen_map
      assign enable_channel[g] = enable_active[g / 2];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel deploy state

  logic [7:0] pending;
  logic [7:0] next_pending;
  logic [7:0] next_driver;
  logic [7:0] start;
  logic [31:0] wait_cnt;
  logic wait_timeout;

  assign start = pending & enable_channel;
  assign wait_timeout = (wait_cnt == 32'h1) && !fire_ok;
  // A new fire in the same cycle as a timeout keeps its channels
  assign next_pending = (pending & ~start & {8{!wait_timeout}})
                        | fire_set;
  assign next_driver = (driver_on & ~fire_done) | start;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 32'h0;
    end else if (fire_ok) begin
      wait_cnt <= 32'(FIRE_WAIT_CYCLES);
    end else if (wait_cnt != 32'h0) begin
      wait_cnt <= wait_cnt - 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= SQAFS_MASK_RESET;
      driver_on <= SQAFS_MASK_RESET;
      deploy_status <= SQAFS_MASK_RESET;
    end else begin
      pending <= next_pending;
      driver_on <= next_driver;
      deploy_status <= next_pending | next_driver;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response word

  function automatic logic [15:0] add_parity(input logic [15:0] w);
    logic [15:0] r;
    r = w;
    r[SQAFS_PARITY_BIT] = 1'b0;
    r[SQAFS_PARITY_BIT] = ~(^r);
    return r;
  endfunction

  logic [15:0] arm_word;
  logic [15:0] fire_word;
  sqafs_resp_t next_resp;

  assign arm_word = add_parity({SQAFS_MODE_DEPLOY, 1'b0, SQAFS_ARM_PATTERN,
                                frame.mask});
  // Status after this frame, so the new channels show as waiting
  assign fire_word = add_parity({SQAFS_MODE_DEPLOY, 1'b0, SQAFS_FIRE_PATTERN,
                                 next_pending | next_driver});

  always_comb begin
    next_resp = miso_resp;
    if (frame_valid) begin
      next_resp.owned = 1'b0;
      next_resp.word = SQAFS_WORD_RESET;
      if (is_arm || is_fire) begin
        next_resp.owned = 1'b1;
        if (busy_hit) begin
          next_resp.word = SQAFS_RESP_BUSY;
        end else if (is_arm) begin
          next_resp.word = arm_word;
        end else if (fire_ok) begin
          next_resp.word = fire_word;
        end else begin
          next_resp.word = SQAFS_RESP_SEQ_ERR;
        end
      end
    end
  end

  // Held until the next frame so it is shifted out during that frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      miso_resp <= '0;
    end else begin
      miso_resp <= next_resp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Observation outputs

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_mask <= SQAFS_MASK_RESET;
      latch_setting <= SQAFS_LATCH_RESET;
      seq_armed <= 1'b0;
    end else begin
      armed_mask <= next_arm_mask;
      latch_setting <= latch_load ? latch_sel : latch_cfg;
      seq_armed <= (next_seq == SQAFS_SEQ_ARMED);
    end
  end

endmodule

/* verif/sqafs_properties.sv */
module sqafs_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic frame_valid,
  input wire logic [15:0] frame_word,
  input wire logic [7:0] fire_done,
  input wire sqafs_pkg::sqafs_resp_t miso_resp,
  input wire logic [7:0] driver_on,
  input wire logic [7:0] deploy_status,
  input wire logic [7:0] armed_mask,
  input wire logic seq_armed
);
  import sqafs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Parity and mode are qualified first; bad-parity words are checked apart in p_badpar
  wire good = frame_valid && ^frame_word && frame_word[15:14] == 2'h1;
  wire is_arm = good && frame_word[12:8] == SQAFS_ARM_PATTERN;
  wire is_fire = good && frame_word[12:8] == SQAFS_FIRE_PATTERN;
  wire busy = |(frame_word[7:0] & deploy_status);
  wire [7:0] hit = armed_mask & frame_word[7:0];
  //////////////////////////////////////////////////////////////////////////
  property p_parity;
    miso_resp.owned |-> ^miso_resp.word;
  endproperty
  a_parity: assert property (p_parity) else $error("response parity");
  property p_arm;
    is_arm && !busy |=> seq_armed && armed_mask == $past(frame_word[7:0])
      && miso_resp.word[7:0] == $past(frame_word[7:0]);
  endproperty
  a_arm: assert property (p_arm) else $error("arm not taken");
  property p_ignore;
    good && !is_arm && !is_fire |=> !miso_resp.owned && !seq_armed;
  endproperty
  a_ignore: assert property (p_ignore) else $error("pattern taken");
  property p_badpar;
    frame_valid && !(^frame_word) |=> !miso_resp.owned && !seq_armed;
  endproperty
  a_badpar: assert property (p_badpar) else $error("bad parity taken");
  property p_seqerr;
    is_fire && !busy && !seq_armed |=> miso_resp.word == SQAFS_RESP_SEQ_ERR;
  endproperty
  a_seqerr: assert property (p_seqerr) else $error("no sequence error");
  property p_busy;
    (is_arm || is_fire) && busy |=> miso_resp.word == SQAFS_RESP_BUSY;
  endproperty
  a_busy: assert property (p_busy) else $error("no busy code");
  property p_fire;
    is_fire && !busy && seq_armed |=> (deploy_status & $past(hit)) ==
      $past(hit) && miso_resp.word[7:0] == deploy_status &&
      (deploy_status & ~$past(deploy_status | hit)) == 8'h00;
  endproperty
  a_fire: assert property (p_fire) else $error("fire masks");
  property p_nofire;
    !(is_fire && seq_armed) |=> (deploy_status & ~$past(deploy_status)) == 0;
  endproperty
  a_nofire: assert property (p_nofire) else $error("status set");
  property p_start;
    1'b1 |=> (driver_on & ~$past(driver_on) & ~$past(deploy_status)) == 0;
  endproperty
  a_start: assert property (p_start) else $error("driver started");
  property p_done;
    |(fire_done & driver_on) |=>
      ((driver_on | deploy_status) & $past(fire_done & driver_on)) == 8'h00;
  endproperty
  a_done: assert property (p_done) else $error("status kept");
  property p_stand;
    !frame_valid |=> $stable(miso_resp);
  endproperty
  a_stand: assert property (p_stand) else $error("response moved");
  property p_reset;
    $rose(rst_n) |-> armed_mask == 8'h00 && !seq_armed && driver_on == 8'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("armed at reset");
  c_fire: cover property (is_fire && seq_armed);
  c_busy: cover property (is_arm && busy);
  c_start: cover property ($rose(|driver_on));
  c_seqerr: cover property (is_fire && !busy && !seq_armed);
endmodule

bind sqafs_sequencer sqafs_properties u_prop (.clk(clk), .rst_n(rst_n),
  .frame_valid(frame_valid), .frame_word(frame_word),
  .fire_done(fire_done), .miso_resp(miso_resp), .driver_on(driver_on),
  .deploy_status(deploy_status), .armed_mask(armed_mask),
  .seq_armed(seq_armed));

/* verif/sqafs_host.sv */
module sqafs_host (
  input wire logic clk,
  output logic frame_valid,
  output logic [15:0] frame_word
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    frame_valid = 1'b0;
    frame_word = 16'h0000;
  end
  // Callers give only the payload; bad flips parity on purpose
  task automatic send(input logic [15:0] w, input logic bad);
    logic [15:0] f;
    f = w;
    f[13] = 1'b0;
    f[13] = ~^f ^ bad;
    @(negedge clk);
    frame_valid = 1'b1;
    frame_word = f;
    @(negedge clk);
    frame_valid = 1'b0;
    frame_word = ~f;
  endtask
endmodule

/* verif/squib_arm_fire_sequencer_tb_top.sv */
module squib_arm_fire_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sqafs_pkg::*;
  logic clk, rst_n, latch_load, frame_valid, seq_armed;
  logic [15:0] frame_word;
  logic [3:0] fire_en;
  logic [7:0] fire_done, driver_on, deploy_status, armed_mask;
  logic [1:0] latch_sel, latch_setting;
  sqafs_resp_t miso_resp;
  int fails = 0;
  int total_checks = 0;
  sqafs_host host (.clk(clk), .frame_valid(frame_valid),
    .frame_word(frame_word));
  // Short counts keep the stretch and fire-wait runs to a few cycles
  sqafs_sequencer #(.STRETCH_UNIT_CYCLES(20), .FIRE_WAIT_CYCLES(50)) uut (
    .clk(clk), .rst_n(rst_n), .frame_valid(frame_valid),
    .frame_word(frame_word), .fire_enable_channel_input(fire_en),
    .fire_done(fire_done), .latch_load(latch_load), .latch_sel(latch_sel),
    .miso_resp(miso_resp), .driver_on(driver_on),
    .deploy_status(deploy_status), .armed_mask(armed_mask),
    .latch_setting(latch_setting), .seq_armed(seq_armed));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask
  task automatic tx(input logic [15:0] w, input logic [15:0] e);
    host.send(w, 1'b0);
    chk("response", e, miso_resp.word);
  endtask
  task automatic done_all;
    @(negedge clk);
    fire_done = 8'hFF;
    @(negedge clk);
    fire_done = 8'h00;
  endtask
  task automatic t_fire;
    fire_en = 4'h1;
    tx(16'h5901, 16'h5901);
    tx(16'h6001, 16'h6001);
    chk("status", 16'h0001, {8'h00, deploy_status});
    @(negedge clk);
    chk("driver", 16'h0001, {8'h00, driver_on});
    tx(16'h5901, SQAFS_RESP_BUSY);
    done_all;
    chk("off", 16'h0000, {8'h00, driver_on | deploy_status});
    tx(16'h6001, SQAFS_RESP_SEQ_ERR);
    chk("driver", 16'h0000, {8'h00, driver_on});
  endtask
  task automatic t_break;
    tx(16'h5901, 16'h5901);
    host.send(16'h2000, 1'b0);
    chk("owned", 16'h0000, {15'h0000, miso_resp.owned});
    tx(16'h6001, SQAFS_RESP_SEQ_ERR);
    for (int i = 0; i < 2; i++) begin
      tx(16'h5901, 16'h5901);
      host.send(i == 0 ? 16'h5901 : 16'h5A01, i == 0);
      chk("owned", 16'h0000, {15'h0000, miso_resp.owned});
      tx(16'h6001, SQAFS_RESP_SEQ_ERR);
    end
  endtask
  task automatic t_mask;
    // Mask 03 gives even payload, so the echo carries bit 13 set
    tx(16'h5903, 16'h7903);
    tx(16'h6081, 16'h6001);
    @(negedge clk);
    chk("driver", 16'h0001, {8'h00, driver_on});
    done_all;
  endtask
  task automatic t_wait;
    fire_en = 4'h0;
    tx(16'h5904, 16'h5904);
    tx(16'h6004, 16'h6004);
    repeat (3) @(negedge clk);
    chk("driver", 16'h0000, {8'h00, driver_on});
    repeat (60) @(negedge clk);
    chk("status", 16'h0000, {8'h00, deploy_status});
  endtask
  task automatic t_stretch;
    latch_sel = 2'h1;
    latch_load = 1'b1;
    @(negedge clk);
    latch_load = 1'b0;
    chk("latch", 16'h0001, {14'h0000, latch_setting});
    fire_en = 4'h2;
    repeat (2) @(negedge clk);
    fire_en = 4'h0;
    tx(16'h5908, 16'h5908);
    tx(16'h6008, 16'h6008);
    @(negedge clk);
    chk("driver", 16'h0008, {8'h00, driver_on});
    done_all;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #5000;
    fails++;
    complete_run;
  end
  initial begin
    rst_n = 1'b0;
    fire_en = 4'h0;
    fire_done = 8'h00;
    latch_load = 1'b0;
    latch_sel = 2'h0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    chk("idle", 16'h0000, {5'h00, armed_mask, seq_armed, latch_setting});
    t_fire;
    t_break;
    t_mask;
    t_wait;
    t_stretch;
    complete_run;
  end
endmodule
